// *** flash_settings_write_parser_regs.svh ***
// Purpose: Constants for the flash settings write parser.
// Assumes: 64-byte command reports arrive one byte per beat.
// Notes:   Offsets are AXI4-Lite byte addresses.
// How it works
// - Report byte 0 must be 0xB1; byte 1 then selects the sub-command.
// - Selector 0x02 stores the string as the manufacturer descriptor.
// - Selector 0x03 stores the string as the product descriptor.
// - Selector 0x04 stores the string as the serial-number descriptor.
// - Characters start at byte 4; positions 0 to 30, at most 31.
// - Each character is two bytes, low byte first, at 4 plus twice position.
// - The first character comes from byte 4; bytes 2 and 3 are header only.
// - Fourth pin bits 2..0: 001 indicator, 010 analog input, 011 analog output.
// - Designation 000 is plain GPIO; values 100 to 111 are ignored.
// - Bit 3 is direction, one input, zero output, only in GPIO role.
// - As GPIO output the fourth pin drives stored bit 4 once loaded after reset or by an apply write.
// - Selector 0x01 writes bytes 2..5 as the four pins' power-up settings.
`ifndef FLASH_SETTINGS_WRITE_PARSER_REGS_SVH
`define FLASH_SETTINGS_WRITE_PARSER_REGS_SVH

`define CMD_WRITE_FLASH   8'hB1
`define SUB_PIN_SETTINGS  8'h01
`define SUB_MANUFACTURER  8'h02
`define SUB_PRODUCT       8'h03
`define SUB_SERIAL        8'h04
`define STR_FIRST_BYTE    6'h04
`define PIN_FIRST_BYTE    6'h02
`define MAX_CHAR_POS      5'h1E
`define STR_HEADER_LEN    8'h02
`define PIN_VAL_BIT       4
`define PIN_DIR_BIT       3
`define PIN_RESERVED_BIT  2
`define PIN_SET_RESET     5'h08
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_PIN_SET       8'h08
`define REG_STR_SEL       8'h0C
`define REG_STR_DATA      8'h10
`define REG_STR_LEN       8'h14
`define CTRL_ENABLE_BIT   0
`define CTRL_APPLY_BIT    1
`define CTRL_RESET        1'h1
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// *** flash_settings_write_parser_pkg.sv ***
// Purpose: Types shared by the flash settings write parser.
// Assumes: Nothing beyond the constants header.
// Notes:   Role codes equal the designation field codes.
`default_nettype none
package flash_settings_write_parser_pkg;
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } reportByte_t;

   typedef enum logic [2:0] {
      ROLE_GPIO       = 3'h0,
      ROLE_INDICATOR  = 3'h1,
      ROLE_ANALOG_IN  = 3'h2,
      ROLE_ANALOG_OUT = 3'h3
   } pinRole_t;

   typedef enum logic [1:0] {
      PS_CMD  = 2'h0,
      PS_SUB  = 2'h1,
      PS_BODY = 2'h2,
      PS_DROP = 2'h3
   } parseState_t;
endpackage
`default_nettype wire

// *** flash_settings_write_parser.sv ***
// Purpose: Parses Write Flash Data reports into pin and string settings.
// Assumes: Report bytes come from logic on the same clock, one per beat.
// Notes:   Settings are exposed over AXI4-Lite and drive the fourth pin.
`include "flash_settings_write_parser_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_settings_write_parser #(
   parameter int NUM_STRINGS = 3,
   parameter int MAX_CHARS   = 31
) (
   // Clock and reset.
   input  wire logic                                         clock,
   input  wire logic                                         srst,
   // Report byte stream.
   input  wire logic                                         rptValid,
   input  wire flash_settings_write_parser_pkg::reportByte_t rptByte,
   output logic                                              rptReady,
   // Fourth general pin and its alternate sources.
   input  wire logic                                         fourthPinIn,
   input  wire logic                                         serialBusActivity,
   output logic                                              fourthPinOut,
   output logic                                              fourthPinOe,
   output flash_settings_write_parser_pkg::pinRole_t         fourthPinRole,
   // AXI4-Lite slave.
   input  wire logic                                         awvalid,
   output logic                                              awready,
   input  wire logic [7:0]                                   awaddr,
   input  wire logic                                         wvalid,
   output logic                                              wready,
   input  wire logic [31:0]                                  wdata,
   input  wire logic [3:0]                                   wstrb,
   output logic                                              bvalid,
   input  wire logic                                         bready,
   output logic [1:0]                                        bresp,
   input  wire logic                                         arvalid,
   output logic                                              arready,
   input  wire logic [7:0]                                   araddr,
   output logic                                              rvalid,
   input  wire logic                                         rready,
   output logic [31:0]                                       rdata,
   output logic [1:0]                                        rresp
);
   flash_settings_write_parser_pkg::parseState_t state;
   flash_settings_write_parser_pkg::pinRole_t    liveRole;
   logic [5:0]  idx;
   logic [7:0]  sub;
   logic [4:0]  pinSet [4];
   logic [7:0]  strLen [NUM_STRINGS];
   logic [15:0] strMem [NUM_STRINGS][MAX_CHARS];
   logic        parserEn;
   logic        loadPending;
   logic        liveDir;
   logic        liveVal;
   logic        pinMeta;
   logic        pinSync;
   logic [1:0]  selSlot;
   logic [4:0]  selPos;
   logic        awHeld;
   logic        wHeld;
   logic [7:0]  awAddrHeld;
   logic [31:0] wDataHeld;
   logic [3:0]  wStrbHeld;
   logic        rptFire;
   logic        isStr;
   logic        pinWr;
   logic        charWr;
   logic [1:0]  curSlot;
   logic [4:0]  charPos;
   logic [6:0]  nChars;
   logic        regWr;
   logic        applyPulse;
   logic        liveLoad;
   logic        next_oe;
   logic        next_out;

   // Maps a string selector onto its storage slot.
   function automatic logic [1:0] slotOf(input logic [7:0] code);
      logic [7:0] d;
      d = code - `SUB_MANUFACTURER;
      return d[1:0];
   endfunction

   function automatic logic isStrSub(input logic [7:0] code);
      return code == `SUB_MANUFACTURER || code == `SUB_PRODUCT || code == `SUB_SERIAL;
   endfunction

   function automatic flash_settings_write_parser_pkg::pinRole_t roleOf(input logic [2:0] d);
      case (d)
         3'h1:    return flash_settings_write_parser_pkg::ROLE_INDICATOR;
         3'h2:    return flash_settings_write_parser_pkg::ROLE_ANALOG_IN;
         3'h3:    return flash_settings_write_parser_pkg::ROLE_ANALOG_OUT;
         default: return flash_settings_write_parser_pkg::ROLE_GPIO;
      endcase
   endfunction

   assign rptReady = 1'b1;
   assign rptFire  = rptValid && parserEn;
   assign isStr    = isStrSub(sub);
   assign curSlot  = slotOf(sub);
   assign charPos  = 5'((idx - `STR_FIRST_BYTE) >> 1);
   // The length byte counts two header bytes plus two bytes per character.
   assign nChars   = (strLen[curSlot] < `STR_HEADER_LEN) ? 7'h00
                     : 7'((strLen[curSlot] - `STR_HEADER_LEN) >> 1);
   assign pinWr    = rptFire && state == flash_settings_write_parser_pkg::PS_BODY
                     && sub == `SUB_PIN_SETTINGS && idx >= `PIN_FIRST_BYTE
                     && idx < `PIN_FIRST_BYTE + 6'h04;
   assign charWr   = rptFire && state == flash_settings_write_parser_pkg::PS_BODY && isStr
                     && idx >= `STR_FIRST_BYTE && charPos <= `MAX_CHAR_POS
                     && {2'h0, charPos} < nChars;

   // Byte position within the current report.
   always_ff @(posedge clock)
   begin
      if (srst)
         idx <= 6'h00;
      else if (rptFire)
         idx <= rptByte.last ? 6'h00 : (idx == 6'h3F ? idx : idx + 6'h01);
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         state <= flash_settings_write_parser_pkg::PS_CMD;
      else if (rptFire && rptByte.last)
         state <= flash_settings_write_parser_pkg::PS_CMD;
      else if (rptFire)
      begin
         unique case (state)
            flash_settings_write_parser_pkg::PS_CMD:
               state <= rptByte.data == `CMD_WRITE_FLASH ? flash_settings_write_parser_pkg::PS_SUB
                        : flash_settings_write_parser_pkg::PS_DROP;
            flash_settings_write_parser_pkg::PS_SUB:
               state <= (rptByte.data == `SUB_PIN_SETTINGS || isStrSub(rptByte.data))
                        ? flash_settings_write_parser_pkg::PS_BODY
                        : flash_settings_write_parser_pkg::PS_DROP;
            flash_settings_write_parser_pkg::PS_BODY:
               state <= flash_settings_write_parser_pkg::PS_BODY;
            flash_settings_write_parser_pkg::PS_DROP:
               state <= flash_settings_write_parser_pkg::PS_DROP;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         sub <= 8'h00;
      else if (rptFire && state == flash_settings_write_parser_pkg::PS_SUB)
         sub <= rptByte.data;
   end

   // Stored pin settings; a reserved designation leaves the old one in place.
   always_ff @(posedge clock)
   begin
      if (srst)
         pinSet <= '{default: `PIN_SET_RESET};
      else if (pinWr)
      begin
         pinSet[2'(idx - `PIN_FIRST_BYTE)][`PIN_VAL_BIT:`PIN_DIR_BIT]
            <= rptByte.data[`PIN_VAL_BIT:`PIN_DIR_BIT];
         if (!rptByte.data[`PIN_RESERVED_BIT])
            pinSet[2'(idx - `PIN_FIRST_BYTE)][2:0] <= rptByte.data[2:0];
      end
   end

   // Byte 2 is the length, byte 3 the type, which is not checked.
   always_ff @(posedge clock)
   begin
      if (srst)
         strLen <= '{default: 8'h00};
      else if (rptFire && state == flash_settings_write_parser_pkg::PS_BODY && isStr
               && idx == `PIN_FIRST_BYTE)
         strLen[curSlot] <= rptByte.data;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         strMem <= '{default: '{default: 16'h0000}};
      else if (charWr)
      begin
         if (idx[0])
            strMem[curSlot][charPos][15:8] <= rptByte.data;
         else
            strMem[curSlot][charPos][7:0] <= rptByte.data;
      end
   end

   // Live pin configuration is taken from the stored byte once after reset and again on each apply write.
   assign liveLoad = loadPending || applyPulse;

   always_ff @(posedge clock)
   begin
      if (srst)
         loadPending <= 1'b1;
      else
         loadPending <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         liveRole <= flash_settings_write_parser_pkg::ROLE_GPIO;
         liveDir  <= 1'b1;
         liveVal  <= 1'b0;
      end
      else if (liveLoad)
      begin
         liveRole <= roleOf(pinSet[3][2:0]);
         liveDir  <= pinSet[3][`PIN_DIR_BIT];
         liveVal  <= pinSet[3][`PIN_VAL_BIT];
      end
   end

   always_comb
   begin
      next_oe  = 1'b0;
      next_out = 1'b0;
      if (liveRole == flash_settings_write_parser_pkg::ROLE_GPIO && !liveDir)
      begin
         next_oe  = 1'b1;
         next_out = liveVal;
      end
      else if (liveRole == flash_settings_write_parser_pkg::ROLE_INDICATOR)
      begin
         next_oe  = 1'b1;
         next_out = serialBusActivity;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         fourthPinOe   <= 1'b0;
         fourthPinOut  <= 1'b0;
         fourthPinRole <= flash_settings_write_parser_pkg::ROLE_GPIO;
      end
      else
      begin
         fourthPinOe   <= next_oe;
         fourthPinOut  <= next_out;
         fourthPinRole <= liveRole;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
      end
      else
      begin
         pinMeta <= fourthPinIn;
         pinSync <= pinMeta;
      end
   end

   // AXI4-Lite write path: address and data are held until both are here.
   assign awready    = !awHeld && !bvalid;
   assign wready     = !wHeld && !bvalid;
   assign regWr      = awHeld && wHeld && !bvalid;
   assign applyPulse = regWr && awAddrHeld == `REG_CTRL && wStrbHeld[0]
                       && wDataHeld[`CTRL_APPLY_BIT];

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         awHeld     <= 1'b0;
         wHeld      <= 1'b0;
         awAddrHeld <= 8'h00;
         wDataHeld  <= 32'h0000_0000;
         wStrbHeld  <= 4'h0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            awHeld     <= 1'b1;
            awAddrHeld <= awaddr;
         end
         else if (regWr)
            awHeld <= 1'b0;
         if (wvalid && wready)
         begin
            wHeld     <= 1'b1;
            wDataHeld <= wdata;
            wStrbHeld <= wstrb;
         end
         else if (regWr)
            wHeld <= 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end
      else if (regWr)
      begin
         bvalid <= 1'b1;
         bresp  <= (awAddrHeld == `REG_CTRL || awAddrHeld == `REG_STR_SEL) ? `RESP_OKAY
                   : `RESP_SLVERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         parserEn <= `CTRL_RESET;
         selSlot  <= 2'h0;
         selPos   <= 5'h00;
      end
      else if (regWr && awAddrHeld == `REG_CTRL && wStrbHeld[0])
         parserEn <= wDataHeld[`CTRL_ENABLE_BIT];
      else if (regWr && awAddrHeld == `REG_STR_SEL)
      begin
         if (wStrbHeld[0])
            selSlot <= wDataHeld[1:0];
         if (wStrbHeld[1])
            selPos <= wDataHeld[12:8];
      end
   end

   // AXI4-Lite read path: one cycle from address to data.
   assign arready = !rvalid;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rresp  <= `RESP_OKAY;
         rdata  <= 32'h0000_0000;
         case (araddr)
            `REG_CTRL:     rdata <= {31'h0000_0000, parserEn};
            `REG_STATUS:   rdata <= {23'h00_0000, pinSync, 3'h0, liveVal, liveDir, liveRole};
            `REG_PIN_SET:  rdata <= {3'h0, pinSet[3], 3'h0, pinSet[2], 3'h0, pinSet[1],
                                     3'h0, pinSet[0]};
            `REG_STR_SEL:  rdata <= {19'h0_0000, selPos, 6'h00, selSlot};
            `REG_STR_DATA: rdata <= (selSlot < 2'(NUM_STRINGS) && selPos <= `MAX_CHAR_POS)
                                    ? {16'h0000, strMem[selSlot][selPos]} : 32'h0000_0000;
            `REG_STR_LEN:  rdata <= {8'h00, strLen[2], strLen[1], strLen[0]};
            default:       rresp <= `RESP_SLVERR;
         endcase
      end
      else if (rready)
         rvalid <= 1'b0;
   end

   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   cmd_gate_a: assert property (
      rptFire && !rptByte.last && state == flash_settings_write_parser_pkg::PS_CMD
      && rptByte.data != `CMD_WRITE_FLASH |=> state == flash_settings_write_parser_pkg::PS_DROP)
      else $error("Report without the write code was not dropped.");
   manuf_store_a: assert property (
      charWr && sub == `SUB_MANUFACTURER && !idx[0]
      |=> strMem[0][$past(charPos)][7:0] == $past(rptByte.data))
      else $error("Manufacturer character was not stored.");
   product_store_a: assert property (
      charWr && sub == `SUB_PRODUCT && idx[0]
      |=> strMem[1][$past(charPos)][15:8] == $past(rptByte.data))
      else $error("Product character was not stored.");
   serial_store_a: assert property (
      charWr && sub == `SUB_SERIAL && idx[0]
      |=> strMem[2][$past(charPos)][15:8] == $past(rptByte.data))
      else $error("Serial character was not stored.");
   char_limit_a: assert property (
      charWr |-> charPos <= `MAX_CHAR_POS && idx >= `STR_FIRST_BYTE)
      else $error("Character written outside the allowed positions.");
   high_byte_a: assert property (
      charWr && idx[0] |=> strMem[$past(curSlot)][$past(charPos)][7:0]
      == $past(strMem[curSlot][charPos][7:0]))
      else $error("High byte write changed the low byte.");
   first_char_a: assert property (
      charWr |-> charPos == 5'((idx - 6'h04) >> 1))
      else $error("First character is not taken from byte four.");
   role_decode_a: assert property (
      liveLoad && pinSet[3][2:0] == 3'h2 |=> ##1 fourthPinRole
      == flash_settings_write_parser_pkg::ROLE_ANALOG_IN)
      else $error("Designation 010 did not select the analog input.");
   reserved_keep_a: assert property (
      pinWr && idx == 6'h05 && rptByte.data[2] |=> pinSet[3][2:0] == $past(pinSet[3][2:0]))
      else $error("Reserved designation was not ignored.");
   input_dir_a: assert property (
      liveRole == flash_settings_write_parser_pkg::ROLE_GPIO && liveDir && $stable(liveRole)
      && $stable(liveDir) |=> !fourthPinOe)
      else $error("Input direction still drives the pin.");
   out_value_a: assert property (
      liveLoad && pinSet[3][2:0] == 3'h0 && !pinSet[3][`PIN_DIR_BIT]
      |=> ##1 fourthPinOe && fourthPinOut == $past(pinSet[3][`PIN_VAL_BIT], 2))
      else $error("Stored output value not driven after a load.");
   pin_store_a: assert property (
      pinWr && idx == 6'h05 |=> pinSet[3][4:3] == $past(rptByte.data[4:3]))
      else $error("Fourth pin byte was not stored.");
   payload_only_a: assert property (
      rptFire && state == flash_settings_write_parser_pkg::PS_BODY && isStr
      && {2'h0, charPos} >= nChars |-> !charWr)
      else $error("Byte beyond the payload was stored.");

   pin_write_c: cover property (pinWr && idx == 6'h05);
   string_write_c: cover property (charWr && sub == `SUB_SERIAL ##1 rptFire && rptByte.last);
   drop_c: cover property (state == flash_settings_write_parser_pkg::PS_DROP);
   apply_c: cover property (applyPulse ##2 fourthPinOe);
endmodule
`default_nettype wire

// *** report_host.sv ***
// Purpose: Host model that hands command reports to the parser a byte per beat.
// Assumes: The caller enters send right after a rising clock edge.
// Notes:   Released data lines show the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module report_host (
   // Clock.
   input  wire logic                                    clock,
   // Report stream.
   output logic                                         rptValid,
   output flash_settings_write_parser_pkg::reportByte_t rptByte,
   input  wire logic                                    rptReady
);
   initial
   begin
      rptValid = 1'b0;
      rptByte  = '0;
   end

   // Each byte is held until an edge sees ready high, for at most 21 edges; the final one is marked.
   task automatic send(input logic [7:0] q[$]);
      int i;
      int j;
      for (i = 0; i < q.size(); i++)
      begin
         rptValid     <= 1'b1;
         rptByte.data <= q[i];
         rptByte.last <= (i == q.size() - 1);
         @(posedge clock);
         for (j = 0; j < 20 && !rptReady; j++)
            @(posedge clock);
      end
      rptValid     <= 1'b0;
      rptByte.data <= ~q[q.size() - 1];
   endtask
endmodule
`default_nettype wire

// *** test_flash_settings_write_parser.sv ***
// Purpose: Self-checking bench for the flash settings write parser.
// Assumes: Register map and timing as handed over with the design.
// Notes:   A bench model of the stored settings is compared at every string, pin-setting and status read.
`include "flash_settings_write_parser_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_flash_settings_write_parser;
   logic        clock, srst, fourthPinIn, serialBusActivity, rptValid, rptReady;
   logic        awvalid, wvalid, bready, arvalid, rready, awready, wready;
   logic        bvalid, arready, rvalid, fourthPinOut, fourthPinOe, eo;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd, r;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   logic [15:0] mem [3][32];
   logic [7:0]  lens [3];
   logic [4:0]  pins [4];
   logic [7:0]  q [$];
   int          fail_count, total_checks, i, d;
   flash_settings_write_parser_pkg::reportByte_t rptByte;
   flash_settings_write_parser_pkg::pinRole_t    fourthPinRole;

   flash_settings_write_parser uut (.clock(clock), .srst(srst), .rptValid(rptValid),
      .rptByte(rptByte), .rptReady(rptReady), .fourthPinIn(fourthPinIn),
      .serialBusActivity(serialBusActivity), .fourthPinOut(fourthPinOut),
      .fourthPinOe(fourthPinOe), .fourthPinRole(fourthPinRole), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp));
   report_host host (.clock(clock), .rptValid(rptValid), .rptByte(rptByte),
      .rptReady(rptReady));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic timed_out();
      fail_count++;
      complete_run();
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] b);
      logic aw;
      logic w;
      int   k;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clock);
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      awaddr  <= a;
      wdata   <= v;
      wstrb   <= 4'hF;
      bready  <= 1'b1;
      for (k = 0; k < 50 && !(aw && w); k++)
      begin
         @(posedge clock);
         if (!aw && awready)
         begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready)
         begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      if (!(aw && w))
         timed_out();
      for (k = 0; k < 50 && !bvalid; k++)
         @(posedge clock);
      if (k == 50)
         timed_out();
      b = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] b);
      int k;
      @(posedge clock);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      for (k = 0; k < 50 && !(arvalid && arready); k++)
         @(posedge clock);
      if (k == 50)
         timed_out();
      arvalid <= 1'b0;
      for (k = 0; k < 50 && !rvalid; k++)
         @(posedge clock);
      if (k == 50)
         timed_out();
      v = rdata;
      b = rresp;
      rready <= 1'b0;
   endtask

   // Claims n characters in the length byte but sends 'sent' of them.
   task automatic str_rep(input logic [7:0] cmd, input int sel, input int n, input int sent,
                          input bit en);
      int k;
      q = {cmd, 8'(sel), 8'(2 + 2 * n), 8'h03};
      for (k = 0; k < sent; k++)
      begin
         rd = $urandom;
         q.push_back(rd[7:0]);
         q.push_back(rd[15:8]);
         if (en && k < n && k <= 30)
            mem[sel - 2][k] = rd[15:0];
      end
      if (en)
         lens[sel - 2] = 8'(2 + 2 * n);
      @(posedge clock);
      host.send(q);
      repeat (2) @(posedge clock);
   endtask

   task automatic str_chk(input int slot, input int upto);
      int k;
      for (k = 0; k <= upto; k++)
      begin
         axi_write(`REG_STR_SEL, (k << 8) | slot, rsp);
         axi_read(`REG_STR_DATA, rd, rsp);
         check("strData", rd, {16'h0, mem[slot][k]});
      end
      axi_read(`REG_STR_LEN, rd, rsp);
      check("strLen", rd, {8'h0, lens[2], lens[1], lens[0]});
   endtask

   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   initial
   begin
      srst = 1'b1;
      fourthPinIn = 1'b1;
      serialBusActivity = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      fail_count = 0;
      total_checks = 0;
      mem = '{default: '0};
      lens = '{default: '0};
      pins = '{default: 5'h08};
      rd = $urandom(32'haa21);
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      repeat (3) @(posedge clock);
      check("oeReset", fourthPinOe, 0);
      check("ready", rptReady, 1);
      axi_read(`REG_CTRL, rd, rsp);
      check("ctrl", rd, 1);
      axi_read(8'h18, rd, rsp);
      check("unmapped", {rsp, rd[29:0]}, 32'h8000_0000);
      axi_write(`REG_STATUS, 32'h0, rsp);
      check("roWrite", rsp, 2);
      str_rep(8'hB1, 2, 3, 4, 1);
      str_rep(8'hB1, 3, 1, 2, 1);
      str_rep(8'hB1, 4, 5, 6, 1);
      str_rep(8'hB1, 3, 31, 30, 1);
      for (i = 0; i < 3; i++)
         str_chk(i, 30);
      str_rep(8'hB2, 2, 2, 2, 0);
      str_rep(8'hB1, 5, 2, 2, 0);
      axi_write(`REG_CTRL, 32'h0, rsp);
      str_rep(8'hB1, 2, 1, 1, 0);
      axi_write(`REG_CTRL, 32'h1, rsp);
      str_chk(0, 4);
      for (d = 0; d < 8; d++)
      begin
         q = {8'hB1, 8'h01};
         for (i = 0; i < 4; i++)
         begin
            rd = $urandom;
            rd[2:0] = (i < 3) ? 3'(rd[9:8] % 3) : 3'(d);
            if (d == 0)
               rd[4:3] = 2'b10;
            q.push_back(rd[7:0]);
            pins[i] = {rd[4:3], rd[2] ? pins[i][2:0] : rd[2:0]};
         end
         q.push_back(8'($urandom));
         q.push_back(8'hFF);
         @(posedge clock);
         host.send(q);
         repeat (2) @(posedge clock);
         axi_read(`REG_PIN_SET, rd, rsp);
         check("pinSet", rd, {3'b0, pins[3], 3'b0, pins[2], 3'b0, pins[1], 3'b0, pins[0]});
         serialBusActivity <= d[0];
         axi_write(`REG_CTRL, 32'h3, rsp);
         check("ctrlResp", rsp, 0);
         repeat (3) @(posedge clock);
         r = 32'(pins[3][2:0]);
         eo = (r == 0) ? !pins[3][3] : (r == 1);
         check("role", fourthPinRole, r);
         check("oe", fourthPinOe, eo);
         if (eo)
            check("out", fourthPinOut, (r == 0) ? pins[3][4] : d[0]);
      end
      axi_read(`REG_STATUS, rd, rsp);
      check("status", {rd[8], rd[2:0]}, {1'b1, pins[3][2:0]});
      complete_run();
   end

   initial
   begin
      #1000000;
      timed_out();
   end
endmodule
`default_nettype wire
